// ---- design/eeprom_pkg.sv ----
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 6;
  localparam int          DATA_W      = 16;
  localparam int          WORDS       = 64;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] HDR_LAST  = 5'h07;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [4:0] READ_END  = 5'h10;

  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;

  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WR_ALL  = 2'h1;
  localparam logic [1:0] EXT_ER_ALL  = 2'h2;
  localparam logic [1:0] EXT_ENABLE  = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS  = 10_000_000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_WAIT  = 3'h0,
    S_HDR   = 3'h1,
    S_DATA  = 3'h2,
    S_READ  = 3'h3,
    S_ARMED = 3'h4,
    S_DONE  = 3'h5
  } state_e;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_ERASE = 3'h1,
    OP_WRITE = 3'h2,
    OP_ERASE_ALL_CMD  = 3'h3,
    OP_WRITE_ALL_CMD  = 3'h4
  } prog_op_e;

endpackage : eeprom_pkg

// ---- design/serial_eeprom.sv ----
module serial_eeprom #(
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic chip_select,
  input  wire logic serial_clock_in,
  input  wire logic serial_in,
  input  wire logic supply_good,
  output logic      serial_out,
  output logic      serial_out_en
);

  // ----------------------------------------------------------------
  // Pin synchronisers: {supply, select, clock, data}
  // ----------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_dly;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_dly  <= 4'h0;
    end else begin
      pin_meta <= {supply_good, chip_select, serial_clock_in, serial_in};
      pin_sync <= pin_meta;
      pin_dly  <= pin_sync;
    end
  end

  logic pwr_ok;
  logic cs_hi;
  logic cs_fall;
  logic sk_rise;
  logic sk_fall;
  logic di;

  assign pwr_ok  = pin_sync[3];
  assign cs_hi   = pin_sync[2];
  assign cs_fall = !pin_sync[2] && pin_dly[2];
  assign sk_rise = pin_sync[1] && !pin_dly[1];
  assign sk_fall = !pin_sync[1] && pin_dly[1];
  assign di      = pin_sync[0];

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  eeprom_pkg::state_e   state,    next_state;
  eeprom_pkg::prog_op_e pend_op,  next_pend_op;
  logic [4:0]           bit_cnt,  next_bit_cnt;
  logic [7:0]           hdr,      next_hdr;
  logic [15:0]          wdata,    next_wdata;
  logic [15:0]          rdata,    next_rdata;
  logic [5:0]           pend_adr, next_pend_adr;
  logic                 prog_en,  next_prog_en;
  logic                 busy,     next_busy;
  logic [eeprom_pkg::CNT_W-1:0] cnt, next_cnt;
  logic                 status_on, next_status_on;
  logic                 rel,      next_rel;
  logic                 next_serial_out;
  logic                 next_serial_out_en;
  logic                 mem_commit;
  logic [7:0]           nh;

  logic [15:0] mem [eeprom_pkg::WORDS];

  assign nh         = {hdr[6:0], di};
  assign mem_commit = pwr_ok && busy && (cnt == '0);

  always_comb begin
    next_state         = state;
    next_pend_op       = pend_op;
    next_bit_cnt       = bit_cnt;
    next_hdr           = hdr;
    next_wdata         = wdata;
    next_rdata         = rdata;
    next_pend_adr      = pend_adr;
    next_prog_en       = prog_en;
    next_busy          = busy;
    next_cnt           = cnt;
    next_status_on     = status_on;
    next_rel           = rel;
    next_serial_out    = serial_out;
    next_serial_out_en = serial_out_en;

    if (!pwr_ok) begin
      // Supply loss aborts any cycle and drops enable
      next_state         = eeprom_pkg::S_WAIT;
      next_prog_en       = 1'b0;
      next_busy          = 1'b0;
      next_status_on     = 1'b0;
      next_rel           = 1'b0;
      next_serial_out_en = 1'b0;
      next_pend_op       = eeprom_pkg::OP_NONE;
    end else begin
      // Own timer, no serial clock needed
      if (busy) begin
        if (cnt == '0) begin
          next_busy = 1'b0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end

      if (!cs_hi) begin
        next_state         = eeprom_pkg::S_WAIT;
        next_serial_out_en = 1'b0;
        next_rel           = 1'b0;
        // Launch only from a complete frame with programming allowed
        if (cs_fall && state == eeprom_pkg::S_ARMED && prog_en && !busy &&
            pend_op != eeprom_pkg::OP_NONE) begin
          next_busy      = 1'b1;
          next_cnt       = eeprom_pkg::CNT_W'(PROG_CYCLES - 1);
          next_status_on = 1'b1;
        end
      end else begin
        if (status_on && state == eeprom_pkg::S_WAIT) begin
          next_serial_out    = !busy;
          next_serial_out_en = 1'b1;
        end
        if (sk_fall && rel) begin
          next_serial_out_en = 1'b0;
          next_status_on     = 1'b0;
          next_rel           = 1'b0;
        end

        unique case (state)
          eeprom_pkg::S_WAIT: begin
            if (sk_rise && di) begin
              if (status_on) begin
                // Dummy one only releases status, it does not open a frame
                next_rel = 1'b1;
              end else if (!busy) begin
                next_state   = eeprom_pkg::S_HDR;
                next_bit_cnt = 5'h00;
              end
            end
          end
          eeprom_pkg::S_HDR: begin
            if (sk_rise) begin
              next_hdr     = nh;
              next_bit_cnt = bit_cnt + 1'b1;
              if (bit_cnt == eeprom_pkg::HDR_LAST) begin
                next_pend_adr = nh[5:0];
                next_bit_cnt  = 5'h00;
                next_pend_op  = eeprom_pkg::OP_NONE;
                next_state    = eeprom_pkg::S_DONE;
                unique case (nh[7:6])
                  eeprom_pkg::OPC_READ: begin
                    next_state         = eeprom_pkg::S_READ;
                    next_rdata         = mem[nh[5:0]];
                    next_serial_out    = 1'b0;
                    next_serial_out_en = 1'b1;
                  end
                  eeprom_pkg::OPC_ERASE: begin
                    next_pend_op = eeprom_pkg::OP_ERASE;
                    next_state   = eeprom_pkg::S_ARMED;
                  end
                  eeprom_pkg::OPC_WRITE: begin
                    next_pend_op = eeprom_pkg::OP_WRITE;
                    next_state   = eeprom_pkg::S_DATA;
                  end
                  eeprom_pkg::OPC_EXT: begin
                    unique case (nh[5:4])
                      eeprom_pkg::EXT_ENABLE:  next_prog_en = 1'b1;
                      eeprom_pkg::EXT_DISABLE: next_prog_en = 1'b0;
                      eeprom_pkg::EXT_ER_ALL: begin
                        next_pend_op = eeprom_pkg::OP_ERASE_ALL_CMD;
                        next_state   = eeprom_pkg::S_ARMED;
                      end
                      eeprom_pkg::EXT_WR_ALL: begin
                        next_pend_op = eeprom_pkg::OP_WRITE_ALL_CMD;
                        next_state   = eeprom_pkg::S_DATA;
                      end
                    endcase
                  end
                endcase
              end
            end
          end
          eeprom_pkg::S_DATA: begin
            if (sk_rise) begin
              next_wdata   = {wdata[14:0], di};
              next_bit_cnt = bit_cnt + 1'b1;
              if (bit_cnt == eeprom_pkg::DATA_LAST) begin
                next_state = eeprom_pkg::S_ARMED;
              end
            end
          end
          eeprom_pkg::S_READ: begin
            if (sk_rise) begin
              next_bit_cnt = bit_cnt + 1'b1;
              if (bit_cnt == eeprom_pkg::READ_END) begin
                next_serial_out_en = 1'b0;
                next_state         = eeprom_pkg::S_DONE;
              end else begin
                next_serial_out = rdata[15];
                next_rdata      = {rdata[14:0], 1'b0};
              end
            end
          end
          eeprom_pkg::S_ARMED, eeprom_pkg::S_DONE: begin
            next_state = state;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= eeprom_pkg::S_WAIT;
      pend_op       <= eeprom_pkg::OP_NONE;
      bit_cnt       <= 5'h00;
      hdr           <= 8'h00;
      wdata         <= 16'h0000;
      rdata         <= 16'h0000;
      pend_adr      <= 6'h00;
      prog_en       <= 1'b0;
      busy          <= 1'b0;
      cnt           <= '0;
      status_on     <= 1'b0;
      rel           <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end else begin
      state         <= next_state;
      pend_op       <= next_pend_op;
      bit_cnt       <= next_bit_cnt;
      hdr           <= next_hdr;
      wdata         <= next_wdata;
      rdata         <= next_rdata;
      pend_adr      <= next_pend_adr;
      prog_en       <= next_prog_en;
      busy          <= next_busy;
      cnt           <= next_cnt;
      status_on     <= next_status_on;
      rel           <= next_rel;
      serial_out    <= next_serial_out;
      serial_out_en <= next_serial_out_en;
    end
  end

  // ----------------------------------------------------------------
  // Array, committed at the end of the timed cycle
  // ----------------------------------------------------------------
  // Not reset: contents are nonvolatile
  always_ff @(posedge clk) begin
    if (mem_commit) begin
      unique case (pend_op)
        eeprom_pkg::OP_ERASE: mem[pend_adr] <= eeprom_pkg::ERASED_WORD;
        eeprom_pkg::OP_WRITE: mem[pend_adr] <= wdata;
        eeprom_pkg::OP_ERASE_ALL_CMD: begin
          for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
            mem[i] <= eeprom_pkg::ERASED_WORD;
          end
        end
        eeprom_pkg::OP_WRITE_ALL_CMD: begin
          // Write all only clears bits; unerased cells keep their zeros
          for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
            mem[i] <= mem[i] & wdata;
          end
        end
        eeprom_pkg::OP_NONE: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence read_hdr_end_s;
    state == eeprom_pkg::S_HDR && sk_rise && cs_hi && pwr_ok &&
      bit_cnt == eeprom_pkg::HDR_LAST && hdr[6:5] == eeprom_pkg::OPC_READ;
  endsequence

  sequence read_bit_s;
    state == eeprom_pkg::S_READ && sk_rise && cs_hi && pwr_ok && bit_cnt < eeprom_pkg::READ_END;
  endsequence

  out_hiz_deselect_a: assert property (!cs_hi |=> !serial_out_en)
    else $error("output driven while deselected");
  start_disabled_a: assert property ($rose(rst_n) |-> !prog_en)
    else $error("programming enabled after reset");
  power_down_a: assert property (!pwr_ok |=> !prog_en && !busy && !serial_out_en)
    else $error("activity after supply loss");
  no_launch_off_a: assert property (!prog_en && !busy |=> !busy)
    else $error("cycle launched while disabled");
  busy_end_a: assert property ($fell(busy) && $past(pwr_ok) |-> $past(cnt) == '0)
    else $error("timed cycle ended early");
  read_dummy_a: assert property (read_hdr_end_s |=> serial_out_en && !serial_out)
    else $error("read dummy zero missing");
  read_shift_a: assert property (read_bit_s |=> serial_out == $past(rdata[15]))
    else $error("read bit mismatch");
  status_busy_a: assert property (busy && cnt != '0 && cs_hi && pwr_ok && status_on &&
                                  state == eeprom_pkg::S_WAIT && !(sk_fall && rel)
                                  |=> serial_out_en && !serial_out)
    else $error("busy status not low");
  status_release_a: assert property (cs_hi && sk_fall && rel |=> !serial_out_en)
    else $error("status not released");

endmodule : serial_eeprom

// ---- test/host_model.sv ----
module host_model (
  output logic      chip_select,
  output logic      serial_clock_in,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Pin level tasks
  // ------------------------------------------------------------
  // Serial clock stands low outside frames
  initial begin
    chip_select     = 1'b0;
    serial_clock_in = 1'b0;
    serial_in       = 1'b0;
  end

  // Data set while clock low, output sampled just before the fall
  task automatic pulse(input logic b, output logic en, output logic dout);
    serial_in = b;
    #62.5 serial_clock_in = 1'b1;
    #62.5;
    en              = serial_out_en;
    dout            = serial_out;
    serial_clock_in = 1'b0;
  endtask : pulse

  task automatic select();
    chip_select = 1'b1;
    #62.5;
  endtask : select

  // Holds deselect well beyond the minimum low time
  task automatic deselect();
    serial_in   = 1'b0;
    chip_select = 1'b0;
    #300;
  endtask : deselect

  // Start bit, opcode, address, data only where the command carries it
  task automatic frame(input logic [1:0] opc, input logic [5:0] addr, input logic [15:0] data,
                       output logic en, output logic dout);
    logic wdata;
    wdata = (opc == 2'h1) || (opc == 2'h0 && addr[5:4] == 2'h1);
    pulse(1'b1, en, dout);
    for (int i = 1; i >= 0; i--) pulse(opc[i], en, dout);
    for (int i = 5; i >= 0; i--) pulse(addr[i], en, dout);
    if (wdata) begin
      for (int i = 15; i >= 0; i--) pulse(data[i], en, dout);
    end
  endtask : frame

  task automatic cmd(input logic [1:0] opc, input logic [5:0] addr);
    logic en;
    logic d;
    select();
    frame(opc, addr, 16'h0000, en, d);
    deselect();
  endtask : cmd

  task automatic read_word(input int zeros, input logic [5:0] addr, output logic [15:0] q, output logic ok);
    logic en;
    logic d;
    select();
    for (int i = 0; i < zeros; i++) pulse(1'b0, en, d);
    frame(2'h2, addr, 16'h0000, en, d);
    ok = en & ~d;
    for (int i = 15; i >= 0; i--) begin
      pulse(1'b0, en, d);
      q[i] = d;
      ok   = ok & en;
    end
    deselect();
  endtask : read_word

  // Program frame, status poll, then dummy one to release the output
  task automatic prog_cycle(input logic [1:0] opc, input logic [5:0] addr, input logic [15:0] data,
                            output logic launched, output logic busy, output logic ready, output logic released);
    logic en;
    logic d;
    select();
    frame(opc, addr, data, en, d);
    deselect();
    select();
    #100;
    launched = serial_out_en;
    busy     = serial_out_en & ~serial_out;
    ready    = 1'b0;
    released = 1'b0;
    if (launched) begin
      // No serial clock while polling the self-timed cycle
      for (int n = 0; n < 100 && !ready; n++) begin
        #100;
        ready = serial_out_en & serial_out;
      end
      pulse(1'b1, en, d);
      #100;
      released = ~serial_out_en;
    end
    deselect();
  endtask : prog_cycle
endmodule : host_model

// ---- test/test_serial_eeprom_64x16_cmd_if.sv ----
module test_serial_eeprom_64x16_cmd_if;
  timeunit 1ns;
  timeprecision 100ps;

  // Short programming time keeps the run brief
  localparam int unsigned PROG_N = 200;

  logic clk;
  logic rst_n;
  logic supply_good;
  logic chip_select;
  logic serial_clock_in;
  logic serial_in;
  logic serial_out;
  logic serial_out_en;
  int   bad_count;
  int   n_checks;

  serial_eeprom #(.PROG_CYCLES(PROG_N)) u_serial_eeprom (
    .clk            (clk),
    .rst_n          (rst_n),
    .chip_select    (chip_select),
    .serial_clock_in(serial_clock_in),
    .serial_in      (serial_in),
    .supply_good    (supply_good),
    .serial_out     (serial_out),
    .serial_out_en  (serial_out_en)
  );

  host_model u_host_model (
    .chip_select    (chip_select),
    .serial_clock_in(serial_clock_in),
    .serial_in      (serial_in),
    .serial_out     (serial_out),
    .serial_out_en  (serial_out_en)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic rd(input int zeros, input logic [5:0] a, input logic [15:0] exp, input string msg);
    logic [15:0] q;
    logic        ok;
    u_host_model.read_word(zeros, a, q, ok);
    chk({15'h0000, ok}, 16'h0001, {msg, " framing"});
    chk(q, exp, msg);
  endtask : rd

  task automatic prog(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d, input logic exp_l,
                      input string msg);
    logic l;
    logic b;
    logic r;
    logic f;
    u_host_model.prog_cycle(opc, a, d, l, b, r, f);
    chk({15'h0000, l}, {15'h0000, exp_l}, {msg, " status"});
    if (exp_l) begin
      chk({15'h0000, b}, 16'h0001, {msg, " busy"});
      if (!r) begin
        bad_count++;
        $display("CHECK FAILED %0t %s never ready", $time, msg);
        summarize();
      end
      chk({15'h0000, f}, 16'h0001, {msg, " release"});
    end
  endtask : prog

  task automatic drive_reset();
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    // Keep pin changes off the sampling edge
    #1;
  endtask : drive_reset

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_erase_all();
    u_host_model.cmd(2'h0, 6'h35);
    prog(2'h0, 6'h2C, 16'h0000, 1'b1, "erase all");
    rd(0, 6'h00, 16'hFFFF, "erased low word");
    rd(0, 6'h3F, 16'hFFFF, "erased top word");
  endtask : s_erase_all

  task automatic s_word_ops();
    prog(2'h1, 6'h2A, 16'hA5C3, 1'b1, "write");
    rd(0, 6'h2A, 16'hA5C3, "written word");
    rd(0, 6'h29, 16'hFFFF, "neighbour word");
    prog(2'h1, 6'h2A, 16'h0F0F, 1'b1, "overwrite");
    rd(0, 6'h2A, 16'h0F0F, "overwritten word");
    prog(2'h3, 6'h2A, 16'h0000, 1'b1, "word erase");
    rd(0, 6'h2A, 16'hFFFF, "erased word");
  endtask : s_word_ops

  task automatic s_write_all();
    prog(2'h0, 6'h17, 16'h3C5A, 1'b1, "write all");
    rd(0, 6'h00, 16'h3C5A, "write all low");
    rd(0, 6'h3F, 16'h3C5A, "write all top");
  endtask : s_write_all

  // Partial write header then deselect must not launch anything
  task automatic s_abort();
    logic en;
    logic d;
    u_host_model.select();
    u_host_model.pulse(1'b1, en, d);
    u_host_model.pulse(1'b0, en, d);
    u_host_model.pulse(1'b1, en, d);
    u_host_model.deselect();
    u_host_model.select();
    #100;
    chk({15'h0000, serial_out_en}, 16'h0000, "aborted frame status");
    u_host_model.deselect();
    rd(3, 6'h3F, 16'h3C5A, "read after leading zeros");
  endtask : s_abort

  task automatic s_disabled();
    u_host_model.cmd(2'h0, 6'h0A);
    prog(2'h1, 6'h01, 16'h1234, 1'b0, "write while disabled");
    prog(2'h0, 6'h2C, 16'h0000, 1'b0, "erase all while disabled");
    rd(0, 6'h01, 16'h3C5A, "read while disabled");
  endtask : s_disabled

  task automatic s_power();
    u_host_model.cmd(2'h0, 6'h3F);
    @(posedge clk) #1 supply_good = 1'b0;
    repeat (10) @(posedge clk);
    #1 supply_good = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    prog(2'h1, 6'h01, 16'h1234, 1'b0, "write after supply dip");
    rd(0, 6'h01, 16'h3C5A, "word kept after dip");
    u_host_model.cmd(2'h0, 6'h30);
    drive_reset();
    prog(2'h3, 6'h01, 16'h0000, 1'b0, "erase after power up");
    rd(0, 6'h01, 16'h3C5A, "word kept after power up");
  endtask : s_power

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    supply_good = 1'b1;
    bad_count   = 0;
    n_checks    = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, serial_out_en}, 16'h0000, "idle output enable");
    s_erase_all();
    s_word_ops();
    s_write_all();
    s_abort();
    s_disabled();
    s_power();
    summarize();
  end
endmodule : test_serial_eeprom_64x16_cmd_if
